// ==== inc/delay_irq_pkg.sv ====
// Constants shared by the delay interrupt and hold controller.
// Assumes a 100 MHz system clock and a single synchronous clock domain.
package delay_irq_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_TIME_NS = 1000000;
  localparam int unsigned TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_W = 17;
  localparam int unsigned NUM_TIMERS = 4;
  localparam int unsigned TIMER_IDX_W = 2;
  localparam int unsigned DELAY_W = 16;
  localparam logic [DELAY_W-1:0] DELAY_MIN_MS = 16'h0001;
  localparam logic [DELAY_W-1:0] DELAY_MAX_MS = 16'hea60;
  localparam int unsigned HANDLER_W = 16;
  localparam int unsigned HOLD_W = 8;
  localparam logic [HOLD_W-1:0] HOLD_RESET = 8'h00;
  localparam logic [15:0] RES_OK = 16'h0000;
  localparam logic [15:0] RES_BAD_HANDLER = 16'h8090;
  localparam logic [15:0] RES_BAD_DELAY = 16'h8091;
  localparam logic [15:0] RES_NOT_STARTED = 16'h80a0;
endpackage

// ==== rtl/delay_irq_and_hold_control.sv ====
// Delay interrupt timers with handler binding, plus a nested hold counter.
// Assumes requests are single-cycle pulses from the program execution engine.
`timescale 1ns/1ps
module delay_irq_and_hold_control (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic start_delay_irq_i,
  input wire logic cancel_delay_irq_i,
  input wire logic [delay_irq_pkg::HANDLER_W-1:0] handler_number_i,
  input wire logic [delay_irq_pkg::DELAY_W-1:0] delay_time_i,
  input wire logic [15:0] tag_word_i,
  input wire logic [delay_irq_pkg::NUM_TIMERS*delay_irq_pkg::HANDLER_W-1:0] handler_table_i,
  input wire logic [delay_irq_pkg::NUM_TIMERS-1:0] handler_valid_i,
  input wire logic hold_irq_servicing_i,
  input wire logic release_irq_servicing_i,
  input wire logic handler_done_i,
  input wire logic irq_ack_i,
  output logic result_valid_o,
  output logic [15:0] result_code_o,
  output logic [delay_irq_pkg::HOLD_W-1:0] hold_count_o,
  output logic irq_o,
  output logic [delay_irq_pkg::HANDLER_W-1:0] irq_handler_o,
  output logic [delay_irq_pkg::NUM_TIMERS-1:0] timer_active_o
);
  import delay_irq_pkg::*;

  // Handler slots: slot i is the delay-interrupt handler listed at table entry i.
  function automatic logic [HANDLER_W-1:0] slot_handler(input logic [TIMER_IDX_W-1:0] s);
    slot_handler = handler_table_i[s*HANDLER_W +: HANDLER_W];
  endfunction

  logic [TICK_W-1:0] tick_cnt;
  logic [DELAY_W-1:0] remain [NUM_TIMERS];
  logic [NUM_TIMERS-1:0] active;
  logic [NUM_TIMERS-1:0] pending;
  logic [HOLD_W-1:0] hold_cnt;
  logic [HOLD_W-1:0] next_hold_cnt;
  logic [15:0] next_result;
  logic [TIMER_IDX_W-1:0] next_serve;
  logic [NUM_TIMERS-1:0] expire;
  logic [NUM_TIMERS-1:0] match;
  logic [TIMER_IDX_W-1:0] slot;
  logic slot_hit;
  logic delay_ok;
  logic req;
  logic ms_tick;
  logic serve_ok;
  logic any_pending;

  wire unused_tag = ^tag_word_i; // Tag word has no effect
  assign ms_tick = (tick_cnt == TICK_W'(TICK_CYCLES - 1));
  assign delay_ok = (delay_time_i >= DELAY_MIN_MS) && (delay_time_i <= DELAY_MAX_MS);
  assign req = start_delay_irq_i | cancel_delay_irq_i;
  assign any_pending = |pending;
  // Service blocked while any hold is in force or an interrupt is in flight
  assign serve_ok = (hold_cnt == HOLD_RESET) && !irq_o;

  always_comb begin
    match = '0;
    for (int i = 0; i < NUM_TIMERS; i++) begin
      match[i] = handler_valid_i[i] && (slot_handler(TIMER_IDX_W'(i)) == handler_number_i);
    end
  end

  always_comb begin
    slot = '0;
    slot_hit = 1'b0;
    next_serve = '0;
    for (int i = NUM_TIMERS - 1; i >= 0; i--) begin
      if (match[i]) begin
        slot = TIMER_IDX_W'(i);
        slot_hit = 1'b1;
      end
      if (pending[i]) begin
        next_serve = TIMER_IDX_W'(i);
      end
    end
  end

  always_comb begin
    expire = '0;
    for (int i = 0; i < NUM_TIMERS; i++) begin
      expire[i] = active[i] && ms_tick && (remain[i] == DELAY_W'(1));
    end
  end

  // Result code priority: handler check first, then delay, then start state
  always_comb begin
    next_result = RES_OK;
    if (!slot_hit) begin
      next_result = RES_BAD_HANDLER;
    end else if (start_delay_irq_i && !delay_ok) begin
      next_result = RES_BAD_DELAY;
    end else if (cancel_delay_irq_i && !active[slot]) begin
      next_result = RES_NOT_STARTED;
    end
  end

  // Handler completion drops every hold at once; release saturates at zero
  always_comb begin
    next_hold_cnt = hold_cnt;
    if (handler_done_i) begin
      next_hold_cnt = HOLD_RESET;
    end else if (hold_irq_servicing_i && !release_irq_servicing_i) begin
      if (hold_cnt != {HOLD_W{1'b1}}) begin
        next_hold_cnt = hold_cnt + HOLD_W'(1);
      end
    end else if (release_irq_servicing_i && !hold_irq_servicing_i) begin
      if (hold_cnt != HOLD_RESET) begin
        next_hold_cnt = hold_cnt - HOLD_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      tick_cnt <= '0;
    end else if (ms_tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + TICK_W'(1);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      active <= '0;
      for (int i = 0; i < NUM_TIMERS; i++) begin
        remain[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        if (expire[i]) begin
          active[i] <= 1'b0; // One shot, no reload
        end else if (active[i] && ms_tick) begin
          remain[i] <= remain[i] - DELAY_W'(1);
        end
      end
      if (start_delay_irq_i && next_result == RES_OK) begin
        active[slot] <= 1'b1; // Restart replaces a running delay
        remain[slot] <= delay_time_i;
      end else if (cancel_delay_irq_i && next_result == RES_OK) begin
        active[slot] <= 1'b0;
      end
    end
  end

  // Pending set wins over service clear in the same cycle
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      pending <= '0;
      irq_o <= 1'b0;
      irq_handler_o <= '0;
    end else begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        if (expire[i]) begin
          pending[i] <= 1'b1;
        end else if (serve_ok && any_pending && !irq_ack_i && next_serve == TIMER_IDX_W'(i)) begin
          pending[i] <= 1'b0;
        end
      end
      if (irq_ack_i) begin
        irq_o <= 1'b0;
      end else if (serve_ok && any_pending) begin
        irq_o <= 1'b1;
        irq_handler_o <= slot_handler(next_serve);
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      hold_cnt <= HOLD_RESET;
      result_valid_o <= 1'b0;
      result_code_o <= RES_OK;
    end else begin
      hold_cnt <= next_hold_cnt;
      result_valid_o <= req | hold_irq_servicing_i | release_irq_servicing_i;
      if (req) begin
        result_code_o <= next_result;
      end else if (hold_irq_servicing_i | release_irq_servicing_i) begin
        result_code_o <= {{(16 - HOLD_W){1'b0}}, next_hold_cnt};
      end
    end
  end

  assign hold_count_o = hold_cnt;
  assign timer_active_o = active;

  // Request context kept one cycle so the checks can look back at it
  logic [TIMER_IDX_W-1:0] last_slot;
  logic [DELAY_W-1:0] last_delay;
  always_ff @(posedge clk_sys_i) begin
    last_slot <= slot;
    last_delay <= delay_time_i;
  end

  a_delay_range: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    start_delay_irq_i && slot_hit && !delay_ok |=> result_code_o == 16'h8091 &&
      active == ($past(active) & ~$past(expire)))
    else $error("Out of range delay was accepted");
  a_start_arms: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    start_delay_irq_i && slot_hit && delay_ok |=> active[last_slot] &&
      remain[last_slot] == last_delay)
    else $error("Valid start did not arm timer");
  a_cancel_stops: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    cancel_delay_irq_i && slot_hit && !start_delay_irq_i |=> !active[last_slot])
    else $error("Cancel left timer running");
  a_bad_handler: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    req && !slot_hit |=> result_valid_o && result_code_o == 16'h8090)
    else $error("Unknown handler not rejected");
  a_not_started: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    cancel_delay_irq_i && !start_delay_irq_i && slot_hit && !active[slot]
      |=> result_code_o == 16'h80a0)
    else $error("Cancel of idle timer not flagged");
  a_hold_defers: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    hold_cnt != 8'h00 && !irq_o |=> !irq_o)
    else $error("Interrupt issued during hold");
  a_done_clears: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    handler_done_i |=> hold_cnt == 8'h00)
    else $error("Handler end kept holds");
  a_pending_served: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    any_pending && serve_ok && !irq_ack_i |=> irq_o)
    else $error("Pending event not serviced");
  a_hold_return: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    hold_irq_servicing_i && !release_irq_servicing_i && !req && !handler_done_i &&
      hold_cnt < 8'h10 |=> result_code_o == 16'(hold_cnt) && hold_cnt == $past(hold_cnt) + 8'h01)
    else $error("Hold did not count up");
  a_one_shot: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    expire[0] && !(start_delay_irq_i && slot == 2'h0) |=> !active[0])
    else $error("Timer reloaded after firing");

  c_fire: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i) expire[0]);
  c_held: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    hold_cnt == 8'h02 && any_pending);
  c_cancel: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    cancel_delay_irq_i && slot_hit && active[slot]);
endmodule

// ==== verification/delay_irq_and_hold_control_tb.sv ====
// Self-checking bench for the delay interrupt and hold controller.
// Assumes the 1 ms prescaler of the package, so only 1 ms delays fire.
`timescale 1ns/1ps
module delay_irq_and_hold_control_tb;
  import delay_irq_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  logic cancel = 1'b0;
  logic hold = 1'b0;
  logic rel = 1'b0;
  logic done = 1'b0;
  logic [15:0] hnum = 16'h0000;
  logic [15:0] dly = 16'h0000;
  logic [15:0] tagw = 16'h0000;
  logic ack, rvalid, irq;
  logic [15:0] code, irq_h, last_h;
  logic [7:0] hcount;
  logic [3:0] active;
  int served;
  int mismatches = 0;
  int n_tests = 0;
  always #5 clk = ~clk;
  delay_irq_and_hold_control u_delay_irq_and_hold_control (.clk_sys_i(clk),
    .reset_n_i(rst_n), .start_delay_irq_i(start), .cancel_delay_irq_i(cancel),
    .handler_number_i(hnum), .delay_time_i(dly), .tag_word_i(tagw),
    .handler_table_i(64'h0017_0016_0015_0014), .handler_valid_i(4'hf),
    .hold_irq_servicing_i(hold), .release_irq_servicing_i(rel), .handler_done_i(done),
    .irq_ack_i(ack), .result_valid_o(rvalid), .result_code_o(code), .hold_count_o(hcount),
    .irq_o(irq), .irq_handler_o(irq_h), .timer_active_o(active));
  exec_engine_model u_exec_engine_model (.clk_i(clk), .reset_n_i(rst_n), .irq_i(irq),
    .handler_i(irq_h), .ack_o(ack), .last_handler_o(last_h), .served_o(served));
  task automatic check(input logic ok, input string msg);
    n_tests++;
    if (!ok) begin
      mismatches++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  // Kind: 0 start, 1 cancel, 2 hold, 3 release
  task automatic req(input int kind, input logic [15:0] h, input logic [15:0] d,
                     input logic [15:0] exp);
    @(posedge clk);
    start <= (kind == 0);
    cancel <= (kind == 1);
    hold <= (kind == 2);
    rel <= (kind == 3);
    hnum <= h;
    dly <= d;
    tagw <= ~tagw;
    @(posedge clk);
    {start, cancel, hold, rel} <= 4'h0;
    #1;
    check(rvalid === 1'b1 && code === exp, "wrong result");
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic t_codes();
    req(0, 16'h0020, 16'h0001, RES_BAD_HANDLER);
    req(1, 16'h0020, 16'h0001, RES_BAD_HANDLER);
    req(0, 16'h0015, 16'h0000, RES_BAD_DELAY);
    req(0, 16'h0015, 16'hea61, RES_BAD_DELAY);
    req(0, 16'h0015, 16'hea60, RES_OK);
    check(active === 4'h2, "timer not running");
    req(1, 16'h0015, 16'h0000, RES_OK);
    check(active === 4'h0, "timer not stopped");
    req(1, 16'h0015, 16'h0000, RES_NOT_STARTED);
  endtask
  task automatic t_hold();
    req(2, 16'h0000, 16'h0000, 16'h0001);
    req(2, 16'h0000, 16'h0000, 16'h0002);
    req(3, 16'h0000, 16'h0000, 16'h0001);
    @(posedge clk);
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    #1;
    check(hcount === 8'h00, "done kept holds");
    req(3, 16'h0000, 16'h0000, 16'h0000);
  endtask
  task automatic t_fire();
    int i;
    req(0, 16'h0014, 16'h0001, RES_OK);
    req(0, 16'h0016, 16'h0001, RES_OK);
    req(1, 16'h0016, 16'h0000, RES_OK);
    req(2, 16'h0000, 16'h0000, 16'h0001);
    for (i = 0; i < 100020 && active !== 4'h0; i++) begin
      @(posedge clk);
      #1;
    end
    // Give a broken hold a few cycles to show an interrupt
    repeat (4) @(posedge clk);
    #1;
    check(active === 4'h0 && irq === 1'b0, "served while held");
    req(3, 16'h0000, 16'h0000, 16'h0000);
    for (i = 0; i < 5 && irq !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    check(irq === 1'b1 && irq_h === 16'h0014, "no pending interrupt");
    repeat (300) @(posedge clk);
    #1;
    check(served === 1 && last_h === 16'h0014, "cancelled timer fired");
    check(irq === 1'b0 && active === 4'h0, "timer reloaded");
  endtask
  initial begin
    #1_300_000;
    mismatches++;
    wrap_up();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    check(rvalid === 1'b0 && irq === 1'b0 && hcount === 8'h00 && active === 4'h0,
          "reset state");
    t_codes();
    t_hold();
    t_fire();
    wrap_up();
  end
endmodule

// ==== verification/exec_engine_model.sv ====
// Behavioural program execution engine that takes interrupts from the controller.
// Assumes irq_o stays up until the acknowledge has been seen.
`timescale 1ns/1ps
module exec_engine_model (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic irq_i,
  input wire logic [15:0] handler_i,
  output logic ack_o,
  output logic [15:0] last_handler_o,
  output int served_o
);
  // One-cycle ack; the guard on ack_o avoids counting the drop cycle twice
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      ack_o <= 1'b0;
      served_o <= 0;
      last_handler_o <= 16'h0000;
    end else begin
      ack_o <= irq_i && !ack_o;
      if (irq_i && !ack_o) begin
        served_o <= served_o + 1;
        last_handler_o <= handler_i;
      end
    end
  end
endmodule
